// >>> swp_defines.svh
// Register indices, addresses, reset values and bit positions of the block
`ifndef SWP_DEFINES_SVH
`define SWP_DEFINES_SVH

// ------------------------------------------------------------
// Register indices on the plain register port
// ------------------------------------------------------------
`define SWP_IDX_GP_RD 4'h0
`define SWP_IDX_GP_WR 4'h1
`define SWP_IDX_RX_RD 4'h2
`define SWP_IDX_RX_WR 4'h3
`define SWP_IDX_UD_RD 4'h4
`define SWP_IDX_UD_WR 4'h5
`define SWP_IDX_RX_START 4'h6
`define SWP_IDX_UD_START 4'h7
`define SWP_IDX_UD_END 4'h8
`define SWP_IDX_GP_DATA 4'h9
`define SWP_IDX_RX_DATA 4'ha
`define SWP_IDX_UD_DATA 4'hb
`define SWP_IDX_CTRL 4'hc
`define SWP_IDX_RX_STORE 4'hd

// ------------------------------------------------------------
// Addresses, reset values and field positions
// ------------------------------------------------------------
`define SWP_ADDR_LAST 16'h5fff
`define SWP_ADDR_ZERO 16'h0000
`define SWP_ADDR_STEP 16'h0001
`define SWP_RX_START_RST 16'h5340
`define SWP_UD_START_RST 16'h6000
`define SWP_UD_END_RST 16'h6001
`define SWP_CTRL_RECEIVE_ENABLE_BIT_BIT 0
`define SWP_ALIGN_BIT 0
`define SWP_LANE_LO 0
`define SWP_LANE_HI 1
`define SWP_NUM_PTR 6
`define SWP_BUF_FULL 2'h2
`define SWP_BUF_EMPTY 2'h0

`endif

// >>> swp_pkg.sv
// Shared types of the window pointer block
package swp_pkg;

   // ------------------------------------------------------------
   // Types
   // ------------------------------------------------------------
   typedef logic [15:0] swp_addr_t;
   typedef logic [7:0] swp_byte_t;
   typedef logic [15:0] swp_word_t;

endpackage : swp_pkg

// >>> swp_mem.sv
// Packet memory with one write port and a registered read port
`timescale 1ns/1ns

module swp_mem
   import swp_pkg::*;
#(
   parameter int DEPTH = 24576
)(
   input wire logic mclk,        // Core clock
   input wire logic rst,         // Synchronous reset, active high
   input wire logic wrEn,        // Store one byte
   input wire swp_addr_t wrAddr, // Byte address of the store
   input wire swp_byte_t wrData, // Byte to store
   input wire logic rdEn,        // Update read data this cycle
   input wire swp_addr_t rdAddr, // Byte address of the fetch
   input wire logic altSel,      // Return altData instead of memory
   input wire swp_word_t altData, // Register value to return
   output swp_word_t rdData      // Registered read data
);

   localparam int AW = $clog2(DEPTH);

   swp_byte_t mem [DEPTH];
   swp_word_t rdData_q;
   swp_word_t rdData_d;
   logic wrHit;
   logic rdHit;

   // ------------------------------------------------------------
   // Read data selection
   // ------------------------------------------------------------
   // Addresses past the top read as zero and ignore stores
   always_comb begin
      wrHit = wrEn && (32'(wrAddr) < DEPTH);
      rdHit = 32'(rdAddr) < DEPTH;
      rdData_d = rdData_q;
      if (rdEn) begin
         if (altSel) begin
            rdData_d = altData;
         end else if (rdHit) begin
            rdData_d = {8'h00, mem[rdAddr[AW-1:0]]};
         end else begin
            rdData_d = 16'h0000;
         end
      end
   end

   // Storage and output register
   always_ff @(posedge mclk) begin
      if (wrHit) begin
         mem[wrAddr[AW-1:0]] <= wrData;
      end
      if (rst) begin
         rdData_q <= 16'h0000;
      end else begin
         rdData_q <= rdData_d;
      end
   end

   assign rdData = rdData_q;

endmodule : swp_mem

// >>> swp_window.sv
// Indirect byte windows with wrapping pointers into packet memory
//
// The plain strobed port and the register addresses are this design's own decisions.
`timescale 1ns/1ns
`include "swp_defines.svh"
// ------------------------------------------------------------
// Function
// RULE_01 - General window access advances its pointer by one byte.
// RULE_02 - General pointer at receive start minus one loads zero first.
// RULE_03 - Otherwise general pointer at top of memory wraps to zero.
// RULE_04 - Receive pointer advances; at top of memory loads receive start.
// RULE_05 - Receive window wraps exactly like the receive store logic.
// RULE_06 - User pointer at user end loads user start, highest priority.
// RULE_07 - Else user pointer at top wraps to zero, else increments.
// RULE_08 - User end at top of memory wraps to user start.
// RULE_09 - User start and end writable anytime, no receive interlock.
// RULE_10 - Host keeps receive start fixed while reception is enabled.
// RULE_11 - User start least significant bit always reads zero.
// RULE_12 - User end least significant bit always reads one.
// RULE_13 - Start above end makes user pointers skip the gap.
// RULE_14 - User bounds beyond memory never match; wrap top to zero.
// RULE_15 - User pointers ignore the receive start boundary.
// RULE_16 - Reads use read pointer, writes write pointer; only it advances.
// RULE_17 - Receive start bit zero fixed; resets to its default address.
// RULE_18 - Windows are one byte; only the low lane writes or returns.
// RULE_19 - Pointers are host-writable 16-bit; wrap uses the old value.
// ------------------------------------------------------------

module swp_window
   import swp_pkg::*;
#(
   parameter int MEM_BYTES = 24576
)(
   input wire logic mclk,          // Core clock, 50 MHz
   input wire logic rst,           // Synchronous reset, active high
   input wire logic [3:0] regAddr, // Register index
   input wire swp_word_t regWrData, // Write data
   input wire logic [1:0] regWrLane, // Byte lanes of a write
   input wire logic regWr,         // Write strobe
   input wire logic regRd,         // Read strobe
   output swp_word_t regRdData,    // Read data, cycle after the strobe
   input wire swp_byte_t rxByteData, // Received byte to store
   input wire logic rxByteValid,   // Received byte offered
   output logic rxByteReady,       // Buffer accepts a byte
   output logic rxEnabled          // Reception is enabled
);

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   swp_addr_t ptr_q [`SWP_NUM_PTR];
   swp_addr_t ptr_d [`SWP_NUM_PTR];
   swp_addr_t rxStart_q, rxStart_d;
   swp_addr_t udStart_q, udStart_d;
   swp_addr_t udEnd_q, udEnd_d;
   swp_addr_t rxStore_q, rxStore_d;
   logic receive_enable_bit_q, receive_enable_bit_d;
   swp_byte_t buf_q [2];
   swp_byte_t buf_d [2];
   logic [1:0] cnt_q, cnt_d;
   logic ready_q, ready_d;

   logic isWindow;
   logic [1:0] win;
   logic [2:0] rdIdx, wrIdx;
   logic winRead, winWrite;
   logic push, pop;
   logic [1:0] pushPos;
   logic altSel;
   swp_word_t altData;
   logic memWrEn;
   swp_addr_t memWrAddr;
   swp_byte_t memWrData;

   // ------------------------------------------------------------
   // Lane merge and wrap functions
   // ------------------------------------------------------------
   // Merge a write into a register by byte lane
   function automatic swp_word_t laneMerge(input swp_word_t old,
                                           input swp_word_t wd,
                                           input logic [1:0] lane);
      swp_word_t r;
      r = old;
      if (lane[`SWP_LANE_LO]) r[7:0] = wd[7:0];
      if (lane[`SWP_LANE_HI]) r[15:8] = wd[15:8];
      return r;
   endfunction : laneMerge

   // Next address of the receive area, shared by window and store logic
   function automatic swp_addr_t rxNext(input swp_addr_t p,
                                        input swp_addr_t rs);
      if (p == `SWP_ADDR_LAST) return rs; // [RULE_04] [RULE_05]
      return p + `SWP_ADDR_STEP;
   endfunction : rxNext

   // Next pointer of window w, from the value held before the access
   function automatic swp_addr_t winNext(input logic [1:0] w,
                                         input swp_addr_t p,
                                         input swp_addr_t rs,
                                         input swp_addr_t us,
                                         input swp_addr_t ue);
      swp_addr_t n;
      n = p + `SWP_ADDR_STEP; // [RULE_01] [RULE_19]
      unique case (w)
         2'h0: begin
            if (p == rs - `SWP_ADDR_STEP) n = `SWP_ADDR_ZERO; // [RULE_02]
            else if (p == `SWP_ADDR_LAST) n = `SWP_ADDR_ZERO; // [RULE_03]
         end
         2'h1: n = rxNext(p, rs); // [RULE_04]
         default: begin
            // Receive start plays no part here, so whole memory is open
            // Bounds past the top never match; only the top wraps [RULE_14]
            if (p == ue) n = us; // [RULE_06] [RULE_08] [RULE_13] [RULE_15]
            else if (p == `SWP_ADDR_LAST) n = `SWP_ADDR_ZERO; // [RULE_07]
         end
      endcase
      return n;
   endfunction : winNext

   // ------------------------------------------------------------
   // Access decode
   // ------------------------------------------------------------
   // Data windows sit at three consecutive indices
   always_comb begin
      isWindow = (regAddr >= `SWP_IDX_GP_DATA) &&
                 (regAddr <= `SWP_IDX_UD_DATA);
      win = 2'(regAddr - `SWP_IDX_GP_DATA);
      rdIdx = {win, 1'b0};
      wrIdx = {win, 1'b1};
      winRead = regRd && isWindow;
      // A high-lane-only write to a window does nothing at all
      winWrite = regWr && isWindow && regWrLane[`SWP_LANE_LO]; // [RULE_18]
   end

   // ------------------------------------------------------------
   // Pointer and boundary registers
   // ------------------------------------------------------------
   // Host writes and window advances; only the pointer used moves
   always_comb begin
      for (int i = 0; i < `SWP_NUM_PTR; i++) begin
         ptr_d[i] = ptr_q[i];
      end
      rxStart_d = rxStart_q;
      udStart_d = udStart_q;
      udEnd_d = udEnd_q;
      receive_enable_bit_d = receive_enable_bit_q;
      if (winRead) begin
         ptr_d[rdIdx] = winNext(win, ptr_q[rdIdx], rxStart_q,
                                udStart_q, udEnd_q); // [RULE_16]
      end
      if (winWrite) begin
         ptr_d[wrIdx] = winNext(win, ptr_q[wrIdx], rxStart_q,
                                udStart_q, udEnd_q); // [RULE_16]
      end
      if (regWr && regAddr < `SWP_IDX_RX_START) begin
         ptr_d[regAddr[2:0]] = laneMerge(ptr_q[regAddr[2:0]], regWrData,
                                         regWrLane); // [RULE_19]
      end
      // Changing this while receiving misplaces the wrap, host's duty
      if (regWr && regAddr == `SWP_IDX_RX_START) begin
         rxStart_d = laneMerge(rxStart_q, regWrData, regWrLane);
      end
      // No interlock against reception for the user bounds
      if (regWr && regAddr == `SWP_IDX_UD_START) begin
         udStart_d = laneMerge(udStart_q, regWrData, regWrLane); // [RULE_09]
      end
      if (regWr && regAddr == `SWP_IDX_UD_END) begin
         udEnd_d = laneMerge(udEnd_q, regWrData, regWrLane); // [RULE_09]
      end
      if (regWr && regAddr == `SWP_IDX_CTRL &&
          regWrLane[`SWP_LANE_LO]) begin
         receive_enable_bit_d = regWrData[`SWP_CTRL_RECEIVE_ENABLE_BIT_BIT];
      end
      rxStart_d[`SWP_ALIGN_BIT] = 1'b0; // [RULE_17]
      udStart_d[`SWP_ALIGN_BIT] = 1'b0; // [RULE_11]
      udEnd_d[`SWP_ALIGN_BIT] = 1'b1; // [RULE_12]
   end

   // Register the pointer group
   always_ff @(posedge mclk) begin
      if (rst) begin
         for (int i = 0; i < `SWP_NUM_PTR; i++) begin
            ptr_q[i] <= `SWP_ADDR_ZERO;
         end
         rxStart_q <= `SWP_RX_START_RST; // [RULE_17]
         udStart_q <= `SWP_UD_START_RST;
         udEnd_q <= `SWP_UD_END_RST;
         receive_enable_bit_q <= 1'b0;
      end else begin
         ptr_q <= ptr_d;
         rxStart_q <= rxStart_d;
         udStart_q <= udStart_d;
         udEnd_q <= udEnd_d;
         receive_enable_bit_q <= receive_enable_bit_d;
      end
   end

   // ------------------------------------------------------------
   // Receive byte buffer and store pointer
   // ------------------------------------------------------------
   // Host window stores win the memory port; the buffer absorbs the stall
   always_comb begin
      push = rxByteValid && ready_q;
      pop = (cnt_q != `SWP_BUF_EMPTY) && receive_enable_bit_q && !winWrite;
      pushPos = cnt_q - {1'b0, pop};
      cnt_d = cnt_q + {1'b0, push} - {1'b0, pop};
      ready_d = cnt_d != `SWP_BUF_FULL;
      buf_d = buf_q;
      if (pop) begin
         buf_d[0] = buf_q[1];
      end
      if (push) begin
         buf_d[pushPos[0]] = rxByteData;
      end
      // Store pointer parks on the area start while reception is off
      rxStore_d = rxStore_q;
      if (!receive_enable_bit_q) begin
         rxStore_d = rxStart_q;
      end else if (pop) begin
         rxStore_d = rxNext(rxStore_q, rxStart_q); // [RULE_05]
      end
   end

   // Register the buffer group
   always_ff @(posedge mclk) begin
      if (rst) begin
         buf_q[0] <= 8'h00;
         buf_q[1] <= 8'h00;
         cnt_q <= `SWP_BUF_EMPTY;
         ready_q <= 1'b0;
         rxStore_q <= `SWP_RX_START_RST;
      end else begin
         buf_q <= buf_d;
         cnt_q <= cnt_d;
         ready_q <= ready_d;
         rxStore_q <= rxStore_d;
      end
   end

   // ------------------------------------------------------------
   // Memory port and read data
   // ------------------------------------------------------------
   // Register reads return a value; window reads fetch the byte
   always_comb begin
      altSel = !isWindow;
      altData = 16'h0000;
      if (regAddr < `SWP_IDX_RX_START) begin
         altData = ptr_q[regAddr[2:0]];
      end else begin
         unique case (regAddr)
            `SWP_IDX_RX_START: altData = rxStart_q;
            `SWP_IDX_UD_START: altData = udStart_q;
            `SWP_IDX_UD_END: altData = udEnd_q;
            `SWP_IDX_CTRL: altData = {15'h0000, receive_enable_bit_q};
            `SWP_IDX_RX_STORE: altData = rxStore_q;
            default: altData = 16'h0000;
         endcase
      end
      memWrEn = winWrite || pop;
      memWrAddr = winWrite ? ptr_q[wrIdx] : rxStore_q; // [RULE_16]
      memWrData = winWrite ? regWrData[7:0] : buf_q[0]; // [RULE_18]
   end

   swp_mem #(
      .DEPTH(MEM_BYTES)
   ) u_mem (
      .mclk(mclk),
      .rst(rst),
      .wrEn(memWrEn),
      .wrAddr(memWrAddr),
      .wrData(memWrData),
      .rdEn(regRd),
      .rdAddr(ptr_q[rdIdx]), // [RULE_16]
      .altSel(altSel),
      .altData(altData),
      .rdData(regRdData)
   );

   assign rxByteReady = ready_q;
   assign rxEnabled = receive_enable_bit_q;

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);

   sequence gpRead;
      regRd && regAddr == `SWP_IDX_GP_DATA;
   endsequence
   sequence gpPlain;
      ptr_q[0] != rxStart_q - `SWP_ADDR_STEP && ptr_q[0] != `SWP_ADDR_LAST;
   endsequence
   sequence udRead;
      regRd && regAddr == `SWP_IDX_UD_DATA;
   endsequence

   gp_step_a: // [RULE_01]
      assert property (gpRead and gpPlain |=>
                       ptr_q[0] == $past(ptr_q[0]) + `SWP_ADDR_STEP)
      else $error("general read pointer did not step by one");
   gp_rx_wrap_a: // [RULE_02]
      assert property (gpRead ##0 ptr_q[0] == rxStart_q - `SWP_ADDR_STEP
                       |=> ptr_q[0] == `SWP_ADDR_ZERO)
      else $error("general pointer missed receive boundary wrap");
   gp_top_wrap_a: // [RULE_03]
      assert property (regWr && regWrLane[0] &&
                       regAddr == `SWP_IDX_GP_DATA &&
                       ptr_q[1] == `SWP_ADDR_LAST
                       |=> ptr_q[1] == `SWP_ADDR_ZERO)
      else $error("general write pointer missed top wrap");
   rx_top_wrap_a: // [RULE_04]
      assert property (regRd && regAddr == `SWP_IDX_RX_DATA &&
                       ptr_q[2] == `SWP_ADDR_LAST
                       |=> ptr_q[2] == $past(rxStart_q))
      else $error("receive pointer did not wrap to area start");
   rx_store_wrap_a: // [RULE_05]
      assert property (pop && receive_enable_bit_q && rxStore_q == `SWP_ADDR_LAST
                       |=> rxStore_q == $past(rxStart_q))
      else $error("store pointer wrapped differently from window");
   ud_end_wrap_a: // [RULE_06]
      assert property (udRead ##0 ptr_q[4] == udEnd_q
                       |=> ptr_q[4] == $past(udStart_q))
      else $error("user pointer did not load user start at end");
   ud_top_wrap_a: // [RULE_07]
      assert property (udRead ##0 ptr_q[4] == `SWP_ADDR_LAST &&
                       udEnd_q != `SWP_ADDR_LAST
                       |=> ptr_q[4] == `SWP_ADDR_ZERO)
      else $error("user pointer did not wrap to zero at top");
   ud_align_a: // [RULE_11]
      assert property (!udStart_q[0] && udEnd_q[0] && !rxStart_q[0])
      else $error("boundary alignment bit broken");
   gp_other_hold_a: // [RULE_16]
      assert property (gpRead |=> ptr_q[1] == $past(ptr_q[1]))
      else $error("general write pointer moved on a read");
   hi_lane_only_a: // [RULE_18]
      assert property (regWr && isWindow && !regWrLane[0]
                       |=> ptr_q[$past(wrIdx)] == $past(ptr_q[wrIdx]))
      else $error("high lane write moved a window pointer");
   buf_bound_a:
      assert property (cnt_q == `SWP_BUF_FULL |-> !rxByteReady)
      else $error("buffer offered room while full");

endmodule : swp_window

// >>> swp_rx_source.sv
// Model of the receive byte source that feeds the window block
`timescale 1ns/1ns

module swp_rx_source
   import swp_pkg::*;
(
   input wire logic mclk,        // Core clock
   input wire logic rxByteReady, // Block has room for a byte
   output swp_byte_t rxByteData, // Offered byte
   output logic rxByteValid      // A byte is offered
);
   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   int sentCnt = 0; // Bytes taken by the block

   // Idle at time zero
   initial begin
      rxByteData = 8'h00;
      rxByteValid = 1'b0;
   end

   // ------------------------------------------------------------
   // Stream driver
   // ------------------------------------------------------------
   // Each byte is held until an edge samples ready high; a gap above zero puts
   // gap+1 idle cycles between bytes, so the source can be prompt or slow
   task automatic send_seq(input swp_byte_t bytes[$], input int gap);
      foreach (bytes[i]) begin
         rxByteData <= bytes[i];
         rxByteValid <= 1'b1;
         do @(posedge mclk); while (rxByteReady !== 1'b1);
         sentCnt++;
         if (gap > 0 || i == bytes.size() - 1) begin
            rxByteValid <= 1'b0;
            // Released data is inverted so a stale byte is never reused
            rxByteData <= ~bytes[i];
            repeat (gap + 1) @(posedge mclk);
         end
      end
   endtask : send_seq

endmodule : swp_rx_source

// >>> tb_top.sv
// Self-checking testbench of the window pointer block
`timescale 1ns/1ns
`include "swp_defines.svh"

module tb_top
   import swp_pkg::*;
;
   // ------------------------------------------------------------
   // Signals
   // ------------------------------------------------------------
   logic mclk = 1'b0;
   logic rst = 1'b1;
   logic [3:0] regAddr = 4'h0;
   swp_word_t regWrData = 16'h0000;
   logic [1:0] regWrLane = 2'h0;
   logic regWr = 1'b0;
   logic regRd = 1'b0;
   swp_word_t regRdData;
   swp_byte_t rxByteData;
   logic rxByteValid;
   logic rxByteReady;
   logic rxEnabled;
   int error_cnt = 0;
   int total_checks = 0;
   swp_byte_t burst[$];

   // 50 MHz core clock
   always #10 mclk = ~mclk;

   swp_window #(.MEM_BYTES(24576)) u_dut (
      .mclk(mclk), .rst(rst), .regAddr(regAddr), .regWrData(regWrData),
      .regWrLane(regWrLane), .regWr(regWr), .regRd(regRd),
      .regRdData(regRdData), .rxByteData(rxByteData),
      .rxByteValid(rxByteValid), .rxByteReady(rxByteReady),
      .rxEnabled(rxEnabled));

   swp_rx_source u_src (
      .mclk(mclk), .rxByteReady(rxByteReady), .rxByteData(rxByteData),
      .rxByteValid(rxByteValid));

   // ------------------------------------------------------------
   // Register port tasks
   // ------------------------------------------------------------
   // Extra edge after each strobe so no strobe is set twice in a step
   task automatic wr(input logic [3:0] a, input swp_word_t d,
                     input logic [1:0] ln);
      regAddr <= a;
      regWrData <= d;
      regWrLane <= ln;
      regWr <= 1'b1;
      @(posedge mclk);
      regWr <= 1'b0;
      @(posedge mclk);
   endtask : wr

   // Read data stand from the strobe edge and hold until the next read strobe
   task automatic rd(input logic [3:0] a, output swp_word_t d);
      regAddr <= a;
      regRd <= 1'b1;
      @(posedge mclk);
      regRd <= 1'b0;
      #1 d = regRdData;
      @(posedge mclk);
   endtask : rd

   task automatic chk(input string n, input swp_word_t e,
                      input swp_word_t g);
      total_checks++;
      if (g !== e) begin
         error_cnt++;
         $display("ERROR %s expected %h seen %h", n, e, g);
      end
   endtask : chk

   task automatic rdchk(input logic [3:0] a, input swp_word_t e,
                        input string n);
      swp_word_t g;
      rd(a, g);
      chk(n, e, g);
   endtask : rdchk

   // Load a pointer, make one window access, read the pointer back
   task automatic adv(input logic [3:0] p, input logic [3:0] w,
                      input swp_addr_t from, input swp_addr_t e,
                      input logic isRead);
      swp_word_t g;
      wr(p, from, 2'h3);
      if (isRead) rd(w, g);
      else wr(w, 16'h005a, 2'h1);
      rdchk(p, e, "pointerAfterAccess");
   endtask : adv

   task automatic test_done;
      $display("checks %0d mismatches %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : test_done

   // Watchdog: the tests need under two hundred cycles
   initial begin
      repeat (20000) @(posedge mclk);
      error_cnt++;
      test_done();
   end

   // ------------------------------------------------------------
   // Tests
   // ------------------------------------------------------------
   initial begin
      repeat (16) @(posedge mclk);
      rst <= 1'b0;
      @(posedge mclk);
      // Reset values and an unmapped index
      rdchk(4'h6, `SWP_RX_START_RST, "rxAreaStart");
      rdchk(4'h7, `SWP_UD_START_RST, "userAreaStart");
      rdchk(4'h8, `SWP_UD_END_RST, "userAreaEnd");
      rdchk(4'h0, `SWP_ADDR_ZERO, "gpReadPointer");
      wr(4'he, 16'h1234, 2'h3);
      rdchk(4'he, 16'h0000, "unmapped");
      $display("test reset done");
      // Forced alignment bits
      wr(4'h7, 16'h1235, 2'h3);
      rdchk(4'h7, 16'h1234, "userAreaStart");
      wr(4'h8, 16'h1234, 2'h3);
      rdchk(4'h8, 16'h1235, "userAreaEnd");
      wr(4'h6, 16'h5341, 2'h3);
      rdchk(4'h6, 16'h5340, "rxAreaStart");
      $display("test alignment done");
      // General window data path and wrapping
      wr(4'h1, 16'h0007, 2'h3);
      wr(4'h9, 16'h00a3, 2'h1);
      rdchk(4'h1, 16'h0008, "gpWritePointer");
      rdchk(4'h0, 16'h0000, "gpReadPointer");
      wr(4'h9, 16'h0055, 2'h2);
      rdchk(4'h1, 16'h0008, "gpWritePointer");
      wr(4'h0, 16'h0007, 2'h3);
      rdchk(4'h9, 16'h00a3, "gpDataWindow");
      rdchk(4'h0, 16'h0008, "gpReadPointer");
      adv(4'h0, 4'h9, 16'h533f, `SWP_ADDR_ZERO, 1'b1);
      adv(4'h1, 4'h9, `SWP_ADDR_LAST, `SWP_ADDR_ZERO, 1'b0);
      $display("test general window done");
      // Receive stream: start set while disabled, buffer fills and stalls
      wr(4'h6, 16'h5ffe, 2'h3);
      rdchk(4'hd, 16'h5ffe, "storePointer");
      burst = {8'h11, 8'h22, 8'h33};
      fork
         u_src.send_seq(burst, 0);
      join_none
      repeat (8) @(posedge mclk);
      chk("rxByteReady", 16'h0000, {15'h0000, rxByteReady});
      chk("bytesTaken", 16'h0002, 16'(u_src.sentCnt));
      wr(4'hc, 16'h0001, 2'h3);
      chk("rxEnabled", 16'h0001, {15'h0000, rxEnabled});
      rdchk(4'hc, 16'h0001, "rxControl");
      for (int i = 0; i < 50 && u_src.sentCnt < 3; i++) @(posedge mclk);
      repeat (4) @(posedge mclk);
      rdchk(4'hd, 16'h5fff, "storePointer");
      wr(4'h2, 16'h5ffe, 2'h3);
      rdchk(4'ha, 16'h0033, "rxDataWindow");
      rdchk(4'ha, 16'h0022, "rxDataWindow");
      rdchk(4'h2, 16'h5ffe, "rxReadPointer");
      adv(4'h3, 4'ha, 16'h5400, 16'h5401, 1'b0);
      burst = {8'h44};
      u_src.send_seq(burst, 3);
      repeat (4) @(posedge mclk);
      rdchk(4'hd, 16'h5ffe, "storePointer");
      $display("test receive done");
      // User window, written while reception stays enabled
      wr(4'h7, 16'h1000, 2'h3);
      wr(4'h8, 16'h1001, 2'h3);
      rdchk(4'h8, 16'h1001, "userAreaEnd");
      adv(4'h5, 4'hb, 16'h1001, 16'h1000, 1'b0);
      adv(4'h4, 4'hb, 16'h0fff, 16'h1000, 1'b1);
      wr(4'h8, `SWP_ADDR_LAST, 2'h3);
      adv(4'h4, 4'hb, `SWP_ADDR_LAST, 16'h1000, 1'b1);
      wr(4'h8, 16'h2001, 2'h3);
      adv(4'h4, 4'hb, `SWP_ADDR_LAST, `SWP_ADDR_ZERO, 1'b1);
      wr(4'h7, 16'h3000, 2'h3);
      adv(4'h4, 4'hb, 16'h2001, 16'h3000, 1'b1);
      wr(4'h7, `SWP_UD_START_RST, 2'h3);
      wr(4'h8, `SWP_UD_END_RST, 2'h3);
      // Receive start is 5ffe here, so 5ffd is the general wrap point
      adv(4'h4, 4'hb, 16'h5ffd, 16'h5ffe, 1'b1);
      adv(4'h5, 4'hb, `SWP_ADDR_LAST, `SWP_ADDR_ZERO, 1'b0);
      $display("test user window done");
      test_done();
   end

endmodule : tb_top
